// file: src/sync_separator_mux.sv
// Sync source selectors and composite sync vertical separator
`timescale 1ns/10ps
`default_nettype none

module sync_separator_mux
	import sync_sep_pkg::*;
#(
	parameter int DIV = SEP_DIV
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Control bytes
	input wire logic [7:0] ctrl_e,
	input wire logic [7:0] ctrl_f,
	input wire logic [7:0] ctrl_15,
	input wire logic [7:0] trigger_count,
	// Sync pins
	input wire sync_in_t sync_in,
	// Selected sync and status
	output var sync_out_t sync_out,
	output logic [SEP_CNT_W-1:0] sep_count
);

	// Separator states: hunting for a long pulse, or timing the gap after it
	typedef enum logic {SEARCH, IN_VSYNC} sep_state_t;

	// Synchroniser stages for the asynchronous pins
	sync_in_t meta_q;
	sync_in_t pin_q;

	// Count period divider
	logic [7:0] div_q;
	logic [7:0] div_d;
	logic tick;

	// Separator state and counter
	sep_state_t state_q;
	sep_state_t state_d;
	logic [SEP_CNT_W-1:0] cnt_q;
	logic [SEP_CNT_W-1:0] cnt_d;
	logic sep_active;

	// Selected sources ahead of the output flops
	logic hsync_sel;
	logic vsync_sel;
	logic hold_sel;
	logic chan_sel;

	// Output flops, one per routed signal
	logic hsync_q;
	logic vsync_q;
	logic hold_q;
	logic chan1_q;
	logic sep_vsync_q;

	// Saturating step, so long pulses or gaps never wrap into false counts
	function automatic logic [SEP_CNT_W-1:0] step(
		input logic [SEP_CNT_W-1:0] v,
		input logic up
	);
		if (up) begin
			step = (v == SEP_CNT_MAX) ? v : SEP_CNT_W'(v + 1'b1);
		end else begin
			step = (v == SEP_CNT_ZERO) ? v : SEP_CNT_W'(v - 1'b1);
		end
	endfunction

	// Two-way pick: a low control bit keeps the first source
	function automatic logic pick(
		input logic ctl,
		input logic src0,
		input logic src1
	);
		pick = ctl ? src1 : src0;
	endfunction

	// Start of vertical sync: count strictly above the trigger
	function automatic logic above_trigger(
		input logic [SEP_CNT_W-1:0] v,
		input logic [SEP_CNT_W-1:0] trig
	);
		above_trigger = (v > trig);
	endfunction

	// End of vertical sync: gap count has reached the trigger
	function automatic logic at_trigger(
		input logic [SEP_CNT_W-1:0] v,
		input logic [SEP_CNT_W-1:0] trig
	);
		at_trigger = (v >= trig);
	endfunction

	// Two-stage synchroniser on all pins; only pin_q is read by logic
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_q <= '0;
			pin_q <= '0;
		end else begin
			meta_q <= sync_in;
			pin_q <= meta_q;
		end
	end

	// Divider next value, back to zero on the tick
	always_comb begin
		if (tick) begin
			div_d = 8'h00;
		end else begin
			div_d = 8'(div_q + 1'b1);
		end
	end

	// Divider register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_d;
		end
	end

	// One tick per separator count period of DIV clocks
	assign tick = (div_q == 8'(DIV - 1));

	// Separator next state and count; csync arrives polarity corrected
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		if (tick) begin
			case (state_q)
				SEARCH: begin
					if (above_trigger(cnt_q, trigger_count)) begin
						state_d = IN_VSYNC;
						cnt_d = SEP_CNT_ZERO;
					end else begin
						cnt_d = step(cnt_q, pin_q.csync);
					end
				end
				IN_VSYNC: begin
					if (at_trigger(cnt_q, trigger_count)) begin
						state_d = SEARCH;
						cnt_d = SEP_CNT_ZERO;
					end else if (!pin_q.csync) begin
						cnt_d = step(cnt_q, 1'b1);
					end else begin
						cnt_d = cnt_q; // Serration pulse: gap count holds
					end
				end
				default: begin
					state_d = SEARCH;
					cnt_d = SEP_CNT_ZERO;
				end
			endcase
		end
	end

	// Separator state register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= SEARCH;
		end else begin
			state_q <= state_d;
		end
	end

	// Separator counter register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_q <= SEP_CNT_ZERO;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Separator verdict, shared by the vsync pick and the status bit
	assign sep_active = (state_q == IN_VSYNC);

	// Source selection
	assign hsync_sel = pick(ctrl_e[HSYNC_SEL_BIT], pin_q.hsync, pin_q.green_sync);
	assign vsync_sel = pick(ctrl_e[VSYNC_SEL_BIT], pin_q.vsync, sep_active);
	assign hold_sel = pick(ctrl_f[HOLD_SEL_BIT], pin_q.hold, vsync_sel);
	assign chan_sel = ctrl_15[CHAN_SEL_BIT];

	// Routed horizontal sync
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hsync_q <= 1'b0;
		end else begin
			hsync_q <= hsync_sel;
		end
	end

	// Routed vertical sync
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			vsync_q <= 1'b0;
		end else begin
			vsync_q <= vsync_sel;
		end
	end

	// Routed hold
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hold_q <= 1'b0;
		end else begin
			hold_q <= hold_sel;
		end
	end

	// Channel select
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			chan1_q <= 1'b0;
		end else begin
			chan1_q <= chan_sel;
		end
	end

	// Separator status bit
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sep_vsync_q <= 1'b0;
		end else begin
			sep_vsync_q <= sep_active;
		end
	end

	// Separator count mirror, in step with the status bit
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sep_count <= SEP_CNT_ZERO;
		end else begin
			sep_count <= cnt_q;
		end
	end

	// Output struct built straight from the flops
	assign sync_out = '{
		hsync: hsync_q,
		vsync: vsync_q,
		hold: hold_q,
		chan1: chan1_q,
		sep_vsync: sep_vsync_q
	};

endmodule

`default_nettype wire

// file: inc/sync_sep_pkg.sv
// Package: constants and carrier types for the sync selector and separator block
package sync_sep_pkg;

	// Control bit positions within their registers
	localparam int HSYNC_SEL_BIT = 3;
	localparam int VSYNC_SEL_BIT = 0;
	localparam int HOLD_SEL_BIT = 5;
	localparam int CHAN_SEL_BIT = 3;

	// Reset values of the control bytes
	localparam logic [7:0] CTRL_E_RESET = 8'h00;
	localparam logic [7:0] CTRL_F_RESET = 8'h00;
	localparam logic [7:0] CTRL_15_RESET = 8'h00;
	localparam logic [7:0] TRIGGER_RESET = 8'h20;

	// Separator timing: count period in ns and system clock period in ns
	localparam int SEP_PERIOD_NS = 200;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SEP_DIV = SEP_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SEP_CNT_W = 8;
	localparam logic [SEP_CNT_W-1:0] SEP_CNT_MAX = 8'hff;
	localparam logic [SEP_CNT_W-1:0] SEP_CNT_ZERO = 8'h00;

	// Raw sync inputs from the pins
	typedef struct packed {
		logic hsync;
		logic vsync;
		logic green_sync;
		logic hold;
		logic csync;
	} sync_in_t;

	// Selected sync outputs
	typedef struct packed {
		logic hsync;
		logic vsync;
		logic hold;
		logic chan1;
		logic sep_vsync;
	} sync_out_t;

endpackage

// file: tb/sync_source.sv
// Partner model: graphics source driving the sync pins
`timescale 1ns/10ps
`default_nettype none
module sync_source
	import sync_sep_pkg::*;
(
	// Pin levels from the bench
	input wire logic [4:0] lvl,
	// Sync pins
	output var sync_in_t pins
);
	// Composite sync is sent already polarity-resolved
	assign pins = lvl;
endmodule
`default_nettype wire

// file: tb/sync_sep_checker.sv
// Checker for the sync selectors and the separator counter
`timescale 1ns/10ps
`default_nettype none
module sync_sep_checker
	import sync_sep_pkg::*;
(
	// Watched ports
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] ctrl_e,
	input wire logic [7:0] ctrl_f,
	input wire logic [7:0] ctrl_15,
	input wire logic [7:0] trigger_count,
	input wire sync_in_t sync_in,
	input wire sync_out_t sync_out,
	input wire logic [SEP_CNT_W-1:0] sep_count
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [2:0] up_q;
	// History of reset, so pin paths are judged only once flushed
	always_ff @(posedge ref_clk) up_q <= {up_q[1:0], !rst};
	sequence held3;
		$stable(sep_count)[*3];
	endsequence
	chk_hsync_src: assert property (&up_q |-> sync_out.hsync == ($past(ctrl_e[3]) ?
		$past(sync_in.green_sync, 3) : $past(sync_in.hsync, 3))) else $error("hsync source");
	chk_vsync_pin: assert property (&up_q && !$past(ctrl_e[0]) |->
		sync_out.vsync == $past(sync_in.vsync, 3)) else $error("vsync pin");
	chk_hold_pin: assert property (&up_q && !$past(ctrl_f[5]) |->
		sync_out.hold == $past(sync_in.hold, 3)) else $error("hold pin");
	chk_chan_sel: assert property (&up_q |->
		sync_out.chan1 == $past(ctrl_15[3])) else $error("channel select");
	chk_count_step: assert property ($changed(sep_count) |-> sep_count == 8'h00 ||
		{1'b0, sep_count} == {1'b0, $past(sep_count)} + 9'h001 ||
		{1'b0, sep_count} + 9'h001 == {1'b0, $past(sep_count)}) else $error("count step");
	chk_tick_rate: assert property ($changed(sep_count) |=> held3)
		else $error("count rate");
	chk_detect_lim: assert property (!sync_out.sep_vsync |->
		{1'b0, sep_count} <= {1'b0, trigger_count} + 9'h001) else $error("late detect");
	chk_clear_zero: assert property ($changed(sync_out.sep_vsync) |->
		sep_count == 8'h00) else $error("count not cleared");
	chk_vsync_sep: assert property ($past(ctrl_e[0]) |->
		sync_out.vsync == sync_out.sep_vsync) else $error("vsync separator");
	chk_hold_vsync: assert property ($past(ctrl_f[5]) |->
		sync_out.hold == sync_out.vsync) else $error("hold vsync");
endmodule
bind sync_separator_mux sync_sep_checker sync_sep_checker_inst (.ref_clk, .rst, .ctrl_e,
	.ctrl_f, .ctrl_15, .trigger_count, .sync_in, .sync_out, .sep_count);
`default_nettype wire

// file: tb/testbench.sv
// Bench: random selector traffic and separator scenarios
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import sync_sep_pkg::*;
	logic ref_clk = 1'b0, rst = 1'b1;
	logic [7:0] ce = 8'h00, cf = 8'h20, cs = 8'h00, tc = 8'hff, cnt;
	logic [4:0] lvl = 5'h01;
	logic [31:0] r = 32'h0818d317;
	int fails = 0, samples_checked = 0;
	sync_in_t pins;
	sync_out_t so;
	// Clock and partner
	always #25 ref_clk = ~ref_clk;
	sync_source sync_source_inst (.lvl, .pins);
	sync_separator_mux sync_separator_mux_inst (.ref_clk, .rst, .ctrl_e(ce), .ctrl_f(cf),
		.ctrl_15(cs), .trigger_count(tc), .sync_in(pins), .sync_out(so), .sep_count(cnt));
	// Next random word
	function automatic logic [31:0] step(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Compare one bit
	task automatic cmp(input string n, input logic e, input logic s);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s expected %b seen %b", n, e, s);
		end
	endtask
	// Verdict and end of run
	task automatic close_out;
		$display("fails %0d samples_checked %0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Bounded wait for the separator output
	task automatic wait_sv(input logic v);
		for (int i = 0; i < 200 && so.sep_vsync !== v; i++) @(negedge ref_clk);
		cmp("sep_vsync", v, so.sep_vsync);
	endtask
	// Main sequence
	initial begin
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		repeat (1100) @(negedge ref_clk);
		cmp("count_top", 1'b1, &cnt);
		lvl = 5'h00;
		repeat (1100) @(negedge ref_clk);
		cmp("count_bottom", 1'b1, cnt == 8'h00);
		tc = 8'h03;
		repeat (400) begin
			@(negedge ref_clk);
			cmp("chan1", cs[3], so.chan1);
			r = step(r);
			{ce[3], ce[0], cf[5], cs[3], lvl} = r[8:0];
		end
		{ce, cf, lvl} = {8'h01, 8'h20, 5'h01};
		wait_sv(1'b1);
		repeat (2) @(negedge ref_clk);
		cmp("vsync", 1'b1, so.vsync);
		cmp("hold", 1'b1, so.hold);
		lvl = 5'h00;
		wait_sv(1'b0);
		lvl = 5'h01;
		repeat (12) @(negedge ref_clk);
		lvl = 5'h00;
		repeat (40) @(negedge ref_clk);
		cmp("short_pulse", 1'b0, so.sep_vsync);
		close_out;
	end
endmodule
`default_nettype wire
